// ===== uart_baud_rx.sv
// apb register file, baud clocking and start/stop sequencing for channel 1
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "uart_rx_params.svh"

// Behaviour
// - bit rate is mck over divisor+1, halved
// - effective divisor stays within two to 127
// - clock chosen by prescaler and select bit
// - select picks low or high 2^k field
// - receive on channel 1, paired channel 0
module uart_baud_rx (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rxd,
   output logic rx_running
);

   logic [7:0] prs_r, prs_nxt;
   logic [15:0] mode0_r, mode0_nxt;
   logic [15:0] mode1_r, mode1_nxt;
   logic [15:0] comm1_r, comm1_nxt;
   logic [6:0] div_r, div_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pslverr_r, pslverr_nxt;
   logic pready_r;
   logic run_r, run_nxt;
   uart_rx_pkg::rx_state_type state_r, state_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic phase_r, phase_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] rxbuf_r, rxbuf_nxt;
   logic full_r, full_nxt;
   logic ferr_r, ferr_nxt;

   uart_rx_pkg::clk_cfg_type cfg;
   logic mck_en;
   logic half_pulse;
   logic restart;
   logic setup, wr, rd;
   logic start_req, stop_req, start_ok;
   logic frame_done;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `OFS_PRESCALER) || (a == `OFS_MODE0) ||
               (a == `OFS_MODE1) || (a == `OFS_COMM1) ||
               (a == `OFS_DATA1) || (a == `OFS_START) ||
               (a == `OFS_STOP) || (a == `OFS_STATUS);
   endfunction

   always_comb begin
      cfg.prs_high = prs_r[7:4];
      cfg.prs_low = prs_r[3:0];
      cfg.cks = mode1_r[`MODE_CKS_BIT];
      cfg.div = div_r;
      restart = (state_r == uart_rx_pkg::RX_IDLE);
   end

   baud_gen #(
      .PRE_W(15)
   ) u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .restart(restart),
      .mck_en(mck_en),
      .half_pulse(half_pulse)
   );

   // bus slave: zero wait states, read data captured in the setup cycle
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && pready_r && pwrite;
      rd = psel && penable && pready_r && !pwrite;
      prs_nxt = prs_r;
      mode0_nxt = mode0_r;
      mode1_nxt = mode1_r;
      comm1_nxt = comm1_r;
      div_nxt = div_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup) begin
         pslverr_nxt = !mapped(paddr);
         prdata_nxt = `WORD_RESET;
         unique case (paddr)
            `OFS_PRESCALER: prdata_nxt[7:0] = prs_r;
            `OFS_MODE0: prdata_nxt[15:0] = mode0_r;
            `OFS_MODE1: prdata_nxt[15:0] = mode1_r;
            `OFS_COMM1: prdata_nxt[15:0] = comm1_r;
            `OFS_DATA1: begin
               prdata_nxt[`DIV_MSB:`DIV_LSB] = div_r;
               prdata_nxt[7:0] = rxbuf_r;
            end
            `OFS_STATUS: begin
               prdata_nxt[`ST_RUN_BIT] = run_r;
               prdata_nxt[`ST_FULL_BIT] = full_r;
               prdata_nxt[`ST_FERR_BIT] = ferr_r;
               prdata_nxt[`ST_BUSY_BIT] =
                  (state_r != uart_rx_pkg::RX_IDLE);
            end
            default: prdata_nxt = `WORD_RESET;
         endcase
      end
      if (wr) begin
         unique case (paddr)
            `OFS_PRESCALER: prs_nxt = pwdata[7:0];
            `OFS_MODE0: mode0_nxt = pwdata[15:0];
            `OFS_MODE1: mode1_nxt = pwdata[15:0];
            `OFS_COMM1: comm1_nxt = pwdata[15:0];
            `OFS_DATA1: div_nxt = pwdata[`DIV_MSB:`DIV_LSB];
            default: div_nxt = div_r;
         endcase
      end
   end

   // start is honoured only with receive enabled and channel 0 paired
   always_comb begin
      start_req = wr && (paddr == `OFS_START) && pwdata[`CH1_BIT];
      stop_req = wr && (paddr == `OFS_STOP) && pwdata[`CH1_BIT];
      start_ok = start_req && comm1_r[`COMM_RXE_BIT] &&
                 mode0_r[`MODE_PAIR_BIT];
      run_nxt = run_r;
      if (stop_req) begin
         run_nxt = 1'b0;
      end else if (start_ok) begin
         run_nxt = 1'b1;
      end
   end

   // receive sequencer; each half-bit pulse is divisor+1 operating clocks
   always_comb begin
      state_nxt = state_r;
      bit_nxt = bit_r;
      phase_nxt = phase_r;
      shift_nxt = shift_r;
      rxbuf_nxt = rxbuf_r;
      frame_done = 1'b0;
      ferr_nxt = ferr_r;
      if (wr && (paddr == `OFS_STATUS) && pwdata[`ST_FERR_BIT]) begin
         ferr_nxt = 1'b0;
      end
      if (!run_r) begin
         state_nxt = uart_rx_pkg::RX_IDLE;
      end else begin
         unique case (state_r)
            uart_rx_pkg::RX_IDLE: begin
               if (!rxd) begin
                  state_nxt = uart_rx_pkg::RX_START;
               end
            end
            uart_rx_pkg::RX_START: begin
               // mid start bit: a glitch that went high is dropped
               if (half_pulse) begin
                  state_nxt = rxd ? uart_rx_pkg::RX_IDLE :
                                    uart_rx_pkg::RX_DATA;
                  bit_nxt = 3'h0;
                  phase_nxt = 1'b0;
               end
            end
            uart_rx_pkg::RX_DATA: begin
               if (half_pulse) begin
                  phase_nxt = !phase_r;
                  if (phase_r) begin
                     shift_nxt = {rxd, shift_r[7:1]};
                     bit_nxt = bit_r + 3'h1;
                     if (bit_r == `LAST_BIT) begin
                        state_nxt = uart_rx_pkg::RX_STOP;
                     end
                  end
               end
            end
            uart_rx_pkg::RX_STOP: begin
               if (half_pulse) begin
                  phase_nxt = !phase_r;
                  if (phase_r) begin
                     frame_done = 1'b1;
                     rxbuf_nxt = shift_r;
                     ferr_nxt = !rxd;
                     state_nxt = uart_rx_pkg::RX_IDLE;
                  end
               end
            end
         endcase
      end
      // a completed frame wins over the read that empties the buffer
      full_nxt = full_r;
      if (rd && (paddr == `OFS_DATA1)) begin
         full_nxt = 1'b0;
      end
      if (frame_done) begin
         full_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prs_r <= `PRS_RESET;
         mode0_r <= `REG16_RESET;
         mode1_r <= `REG16_RESET;
         comm1_r <= `REG16_RESET;
         div_r <= `DIV_RESET;
         prdata_r <= `WORD_RESET;
         pslverr_r <= 1'b0;
         pready_r <= 1'b0;
         run_r <= 1'b0;
         state_r <= uart_rx_pkg::RX_IDLE;
         bit_r <= 3'h0;
         phase_r <= 1'b0;
         shift_r <= `BYTE_RESET;
         rxbuf_r <= `BYTE_RESET;
         full_r <= 1'b0;
         ferr_r <= 1'b0;
      end else begin
         prs_r <= prs_nxt;
         mode0_r <= mode0_nxt;
         mode1_r <= mode1_nxt;
         comm1_r <= comm1_nxt;
         div_r <= div_nxt;
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         pready_r <= 1'b1;
         run_r <= run_nxt;
         state_r <= state_nxt;
         bit_r <= bit_nxt;
         phase_r <= phase_nxt;
         shift_r <= shift_nxt;
         rxbuf_r <= rxbuf_nxt;
         full_r <= full_nxt;
         ferr_r <= ferr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign rx_running = run_r;

   chk_start_pairing: assert property (
      @(posedge pclk) disable iff (!presetn)
      (start_req && !mode0_r[`MODE_PAIR_BIT] && !run_r) |=> !run_r)
      else $error("start accepted without channel 0 paired");
   chk_start_accept: assert property (
      @(posedge pclk) disable iff (!presetn)
      (start_ok && !stop_req) |=> run_r)
      else $error("legal start did not run channel 1");
   chk_sample_timing: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_r == uart_rx_pkg::RX_DATA && !half_pulse && run_r)
      |=> $stable(bit_r))
      else $error("data bit advanced without a half-bit pulse");

   cov_frame: cover property (@(posedge pclk) disable iff (!presetn)
      frame_done && rxd);
   cov_ferr: cover property (@(posedge pclk) disable iff (!presetn)
      frame_done && !rxd);
   cov_refused: cover property (@(posedge pclk) disable iff (!presetn)
      start_req && !start_ok);
   cov_glitch: cover property (@(posedge pclk) disable iff (!presetn)
      state_r == uart_rx_pkg::RX_START && half_pulse && rxd);

endmodule

// ===== uart_rx_params.svh
// register offsets, field positions and reset values of the receive channel
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH

`define OFS_PRESCALER 8'h00
`define OFS_MODE0 8'h04
`define OFS_MODE1 8'h08
`define OFS_COMM1 8'h0C
`define OFS_DATA1 8'h10
`define OFS_START 8'h14
`define OFS_STOP 8'h18
`define OFS_STATUS 8'h1C

`define MODE_CKS_BIT 15
`define MODE_PAIR_BIT 0
`define COMM_RXE_BIT 14
`define DIV_MSB 15
`define DIV_LSB 9
`define CH1_BIT 1
`define ST_RUN_BIT 0
`define ST_FULL_BIT 1
`define ST_FERR_BIT 2
`define ST_BUSY_BIT 3

`define DIV_MIN 7'h02
`define DIV_MAX 7'h7F
`define LAST_BIT 3'h7

`define PRS_RESET 8'h00
`define REG16_RESET 16'h0000
`define DIV_RESET 7'h00
`define BYTE_RESET 8'h00
`define WORD_RESET 32'h0000_0000

`endif

// ===== uart_rx_pkg.sv
// types shared by the baud generator and the receive channel
package uart_rx_pkg;

   typedef struct packed {
      logic [3:0] prs_high;
      logic [3:0] prs_low;
      logic cks;
      logic [6:0] div;
   } clk_cfg_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b11,
      RX_STOP = 2'b10
   } rx_state_type;

endpackage

// ===== baud_gen.sv
// prescaler and 7-bit divisor producing half-bit pulses
`include "uart_rx_params.svh"

module baud_gen #(
   parameter int PRE_W = 15
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // configuration
   input wire uart_rx_pkg::clk_cfg_type cfg,
   input wire logic restart,
   // timing enables
   output logic mck_en,
   output logic half_pulse
);

   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] pre_nxt;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic [PRE_W-1:0] mask;
   logic [6:0] eff_div;

   function automatic logic [PRE_W-1:0] pre_mask(input logic [3:0] k);
      pre_mask = (PRE_W'(1) << k) - PRE_W'(1);
   endfunction

   // a forbidden divisor is raised to the least legal one
   function automatic logic [6:0] clamp_div(input logic [6:0] d);
      clamp_div = (d < `DIV_MIN) ? `DIV_MIN : d;
   endfunction

   always_comb begin
      mask = pre_mask(cfg.cks ? cfg.prs_high : cfg.prs_low);
      mck_en = ((pre_r & mask) == mask);
      eff_div = clamp_div(cfg.div);
      half_pulse = mck_en && !restart && (cnt_r == eff_div);
      pre_nxt = pre_r + PRE_W'(1);
      cnt_nxt = cnt_r;
      if (restart) begin
         cnt_nxt = 7'h00;
      end else if (mck_en) begin
         // divisor counter runs on the operating clock enable
         cnt_nxt = (cnt_r == eff_div) ? 7'h00 : cnt_r + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= '0;
         cnt_r <= `DIV_RESET;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // helper: operating clock ticks seen since the last half-bit pulse
   logic [7:0] tick_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r <= 8'h00;
      end else if (restart || half_pulse) begin
         tick_r <= 8'h00;
      end else if (mck_en) begin
         tick_r <= tick_r + 8'h01;
      end
   end

   chk_half_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      half_pulse |-> tick_r == {1'b0, eff_div})
      else $error("half bit not divisor plus one ticks");
   chk_div_range: assert property (
      @(posedge pclk) disable iff (!presetn)
      eff_div >= `DIV_MIN && eff_div <= `DIV_MAX)
      else $error("effective divisor out of range");
   chk_mck_full: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!cfg.cks && cfg.prs_low == 4'h0) |-> mck_en)
      else $error("undivided operating clock missed a cycle");
   // a prescaler rewrite between the two cycles is exempt
   chk_mck_half: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg.cks && cfg.prs_high == 4'h1 && mck_en) ##1 $stable(cfg)
      |-> !mck_en)
      else $error("high prescaler by two ticked twice in a row");

endmodule

// ===== uart_tx_model.sv
// behavioural remote 8n1 transmitter driving the receive line
module uart_tx_model (
   // clock
   input wire logic pclk,
   // frame request
   input wire logic go,
   input wire logic [7:0] data,
   input wire logic [15:0] bit_cyc,
   input wire logic bad_stop,
   // line
   output logic rxd,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] frame;
   initial begin
      rxd = 1'b1;
      busy = 1'b0;
   end
   // line idles high; a cleared stop bit provokes a framing error
   always begin
      @(posedge pclk);
      if (go) begin
         frame = {~bad_stop, data, 1'b0};
         busy <= 1'b1;
         for (int i = 0; i < 10; i++) begin
            rxd <= frame[i];
            if (i == 9 && bad_stop) begin
               // short break: low past the stop sample, high again before
               // the restarted start check; holds for the bench's settings
               repeat (bit_cyc * 3 / 4) @(posedge pclk);
               rxd <= 1'b1;
               repeat (bit_cyc - bit_cyc * 3 / 4) @(posedge pclk);
            end else begin
               repeat (bit_cyc) @(posedge pclk);
            end
         end
         rxd <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule

// ===== test_uart_baud_rx.sv
// self-checking bench: apb register traffic and received frames
`include "uart_rx_params.svh"
module test_uart_baud_rx;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
   logic pready, pslverr, rxd, rx_running, busy, go = 1'b0, bad = 1'b0;
   logic [7:0] txb = 8'h00;
   logic [15:0] bitc = 16'h0006;
   logic [33:0] notes[$];
   logic [33:0] nt;
   logic [7:0] prs_t[4] = '{8'h50, 8'h13, 8'h02, 8'h20};
   logic cks_t[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic [6:0] div_t[4] = '{7'h02, 7'h03, 7'h7F, 7'h05};
   int n_fail = 0, n_checks = 0, seed = 32'h77c1_9d3d, k, n;

   uart_baud_rx uart_baud_rx_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
      .rx_running(rx_running));
   uart_tx_model uart_tx_model_i (.pclk(pclk), .go(go), .data(txb),
      .bit_cyc(bitc), .bad_stop(bad), .rxd(rxd), .busy(busy));

   always #50 pclk = ~pclk;

   task automatic check(input string what, input logic [32:0] seen,
                        input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // reads leave a note; the monitor below compares when data appear
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [33:0] note);
      int c = 0;
      if (!w) notes.push_back(note);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         c++;
      end while (pready !== 1'b1 && c < 20);
      if (c >= 20) begin
         n_fail++;
         give_verdict();
      end
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      apb(1'b0, a, 32'h0000_0000, {1'b1, exp});
   endtask

   always @(posedge pclk) begin
      if (psel & penable & pready & !pwrite & notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt[33]) check("read", {pslverr, prdata}, nt[32:0]);
      end
   end

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(`OFS_STATUS, 33'h0);
      rd(`OFS_DATA1, 33'h0);
      rd(8'h20, 33'h1_0000_0000);
      wr(8'h24, 32'hFFFF_FFFF);
      // neither pairing nor receive enable set: start must be ignored
      wr(`OFS_START, 32'h0000_0002);
      rd(`OFS_STATUS, 33'h0);
      for (int f = 0; f < 4; f++) begin
         // stop before touching the clock setup
         wr(`OFS_STOP, 32'h0000_0002);
         wr(`OFS_PRESCALER, {24'h00_0000, prs_t[f]});
         wr(`OFS_MODE0, 32'h0000_0001);
         wr(`OFS_MODE1, {16'h0000, cks_t[f], 15'h0000});
         wr(`OFS_DATA1, {16'h0000, div_t[f], 9'h000});
         wr(`OFS_COMM1, 32'h0000_4000);
         repeat (4) @(posedge pclk);
         wr(`OFS_START, 32'h0000_0002);
         check("running", {32'h0, rx_running}, 33'h1);
         k = cks_t[f] ? prs_t[f][7:4] : prs_t[f][3:0];
         bitc <= 16'((2 * (div_t[f] + 1)) << k);
         txb <= 8'($random(seed));
         bad <= (f == 3);
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         n = 0;
         do begin
            apb(1'b0, `OFS_STATUS, 32'h0000_0000, 34'h0);
            n++;
         end while (rdv[1] !== 1'b1 && n < 5000);
         if (n >= 5000) begin
            n_fail++;
            give_verdict();
         end
         // a low stop bit re-arms start detection; let the line settle
         n = 0;
         while (busy && n < 20000) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 20000) begin
            n_fail++;
            give_verdict();
         end
         repeat (bitc) @(posedge pclk);
         apb(1'b0, `OFS_STATUS, 32'h0000_0000, 34'h0);
         check("status", {1'b0, rdv}, {30'h0, bad, 2'b11});
         rd(`OFS_DATA1, {17'h0_0000, div_t[f], 1'b0, txb});
         if (bad) wr(`OFS_STATUS, 32'h0000_0004);
         rd(`OFS_STATUS, 33'h1);
      end
      wr(`OFS_STOP, 32'h0000_0002);
      rd(`OFS_STATUS, 33'h0);
      give_verdict();
   end
endmodule
